// ==== ptc_fifo2.sv ====
`timescale 1ns/10ps

// ****************************************************************
// Shared constants and carriers
// ****************************************************************
package ptc_pkg;
    localparam int PTC_NCH = 8;
    localparam int PTC_NPER = 4;
    localparam int PTC_PTR_W = 32;
    localparam int PTC_CNT_W = 16;
    localparam int PTC_DAT_W = 16;
    localparam logic [2:0] PTC_TX_BASE = 3'h4;
    localparam logic [31:0] PTC_STEP_BYTE = 32'h1;
    localparam logic [31:0] PTC_STEP_HALF = 32'h2;
    localparam logic [15:0] PTC_CNT_ZERO = 16'h0;
    localparam logic [15:0] PTC_CNT_LAST = 16'h1;
    localparam logic [31:0] PTC_PTR_RST = 32'h0;
    localparam logic [15:0] PTC_DAT_RST = 16'h0;

    typedef logic [PTC_DAT_W-1:0] ptc_word_t;

    typedef struct packed {
        logic [2:0] chan;
        logic sel_cnt;
        logic wide;
        logic [31:0] data;
    } ptc_prog_t;

    typedef struct packed {
        logic we;
        logic wide;
        logic [31:0] addr;
        ptc_word_t wdata;
    } ptc_mem_cmd_t;

    typedef struct packed {
        logic [1:0] periph;
        ptc_word_t data;
    } ptc_tx_item_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WRITE = 3'b001,
        ST_READ = 3'b010,
        ST_RWAIT = 3'b011,
        ST_UPDATE = 3'b100
    } ptc_state_t;
endpackage

// ****************************************************************
// Two-entry buffer, head entry always in slot 0
// ****************************************************************
module ptc_fifo2
    import ptc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input ptc_pkg::ptc_tx_item_t in_item,
    output logic out_valid,
    input wire logic out_ready,
    output ptc_pkg::ptc_tx_item_t out_item
);
    logic valid0_reg, valid1_reg;
    ptc_tx_item_t item0_reg, item1_reg;
    wire push = in_valid && in_ready;
    wire pop = valid0_reg && out_ready;
    // Slot 0 refills from slot 1 first so the order is kept
    wire valid0_next = pop ? (valid1_reg || push) : (valid0_reg || push);
    wire valid1_next = pop ? 1'b0 : (valid1_reg || (push && valid0_reg));
    wire ptc_tx_item_t item0_next = (pop && valid1_reg) ? item1_reg :
        ((push && (pop || !valid0_reg)) ? in_item : item0_reg);
    wire ptc_tx_item_t item1_next = (push && valid0_reg && !pop) ?
        in_item : item1_reg;

    assign in_ready = !valid1_reg;
    assign out_valid = valid0_reg;
    assign out_item = item0_reg;

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            valid0_reg <= 1'b0;
            valid1_reg <= 1'b0;
        end
        else
        begin
            valid0_reg <= valid0_next;
            valid1_reg <= valid1_next;
        end
    end

    always_ff @(posedge mclk)
    begin
        item0_reg <= item0_next;
        item1_reg <= item1_next;
    end
endmodule // ptc_fifo2

// ==== ptc_mem_model.sv ====
`timescale 1ns/10ps

// ****************************************************************
// Memory side: grant after a chosen wait, read data a cycle later
// ****************************************************************
module ptc_mem_model
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [1:0] slow,
    input wire logic mem_req,
    input ptc_pkg::ptc_mem_cmd_t mem_cmd,
    output logic mem_gnt,
    output logic mem_rvalid,
    output ptc_pkg::ptc_word_t mem_rdata,
    output logic [31:0] last_waddr,
    output ptc_pkg::ptc_word_t last_wdata,
    output logic [7:0] gnt_n
);
    import ptc_pkg::*;
    logic [1:0] wait_reg;
    logic take;
    assign take = mem_req && (wait_reg >= slow);
    assign mem_gnt = take;
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            wait_reg <= 2'h0;
            mem_rvalid <= 1'b0;
            mem_rdata <= 16'h0;
            last_waddr <= 32'h0;
            last_wdata <= 16'h0;
            gnt_n <= 8'h0;
        end
        else
        begin
            wait_reg <= (mem_req && !take) ? wait_reg + 2'h1 : 2'h0;
            mem_rvalid <= take && !mem_cmd.we;
            // Idle data toggles so a stale sample never looks right
            mem_rdata <= (take && !mem_cmd.we) ?
                mem_cmd.addr[15:0] ^ 16'h5a5a : ~mem_rdata;
            gnt_n <= gnt_n + {7'h0, take};
            if (take && mem_cmd.we)
            begin
                last_waddr <= mem_cmd.addr;
                last_wdata <= mem_cmd.wdata;
            end
        end
    end
endmodule // ptc_mem_model

// ==== ptc_tb_top.sv ====
`timescale 1ns/10ps

// ****************************************************************
// Bench for the transfer channels
// ****************************************************************
module ptc_tb_top;
    import ptc_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic prog_valid = 1'b0;
    ptc_prog_t prog = '0;
    logic [2:0] rd_chan = 3'h0;
    logic [31:0] rd_ptr;
    logic [15:0] rd_cnt;
    logic [3:0] rx_valid = 4'h0;
    ptc_word_t [3:0] rx_data = '0;
    logic [3:0] rx_ack;
    logic [3:0] tx_req = 4'h0;
    logic tx_valid;
    logic tx_ready = 1'b0;
    ptc_tx_item_t tx_item;
    logic mem_req;
    ptc_mem_cmd_t mem_cmd;
    logic mem_gnt;
    logic mem_rvalid;
    ptc_word_t mem_rdata;
    logic [7:0] eot;
    logic [1:0] slow = 2'h0;
    logic [31:0] last_waddr;
    ptc_word_t last_wdata;
    logic [7:0] gnt_n;
    logic [7:0] g0;
    logic got;
    logic last_wide = 1'b0;
    int num_errors = 0;
    int tests_run = 0;
    int eot_n [8] = '{default: 0};
    ptc_tx_item_t got_q [$];
    // Rows: pointer, count; readback must return both unchanged
    localparam logic [47:0] ROWS [8] = '{48'h0000_0000_0001,
        48'hffff_ffff_ffff, 48'h1234_5678_0100, 48'h0000_0002_8000,
        48'h8000_0000_0003, 48'h0fff_fffe_00ff, 48'h0000_0400_4000,
        48'h7fff_0001_fffe};

    always #5 mclk = ~mclk;

    ptc_top dut (.mclk(mclk), .rst_b(rst_b), .prog_valid(prog_valid),
        .prog(prog), .rd_chan(rd_chan), .rd_ptr(rd_ptr), .rd_cnt(rd_cnt),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_ack(rx_ack),
        .tx_req(tx_req), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_item(tx_item), .mem_req(mem_req), .mem_cmd(mem_cmd),
        .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
        .eot(eot));
    ptc_mem_model mem (.mclk(mclk), .rst_b(rst_b), .slow(slow),
        .mem_req(mem_req), .mem_cmd(mem_cmd), .mem_gnt(mem_gnt),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
        .last_waddr(last_waddr), .last_wdata(last_wdata), .gnt_n(gnt_n));

    always @(posedge mclk)
    begin
        for (int i = 0; i < 8; i++)
            eot_n[i] += (eot[i] === 1'b1) ? 1 : 0;
        if (tx_valid === 1'b1 && tx_ready === 1'b1)
            got_q.push_back(tx_item);
        // Item size as the memory saw it on the granted command
        if (mem_req === 1'b1 && mem_gnt === 1'b1)
            last_wide <= mem_cmd.wide;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
            num_errors++;
        end
    endtask

    task automatic wr(input logic [2:0] c, input logic s, input logic w,
        input logic [31:0] d);
        prog_valid = 1'b1;
        prog = '{chan: c, sel_cnt: s, wide: w, data: d};
        tick(1);
        prog_valid = 1'b0;
        tick(1);
    endtask

    task automatic rdb(input logic [2:0] c, input logic [31:0] p,
        input logic [15:0] n);
        rd_chan = c;
        tick(2);
        chk(rd_ptr, p);
        chk({16'h0, rd_cnt}, {16'h0, n});
    endtask

    // Word held until taken; gives up after a bounded wait
    task automatic rxw(input int p, input ptc_word_t d, output logic ok);
        rx_valid[p] = 1'b1;
        rx_data[p] = d;
        ok = 1'b0;
        for (int i = 0; i < 12 && ok !== 1'b1; i++)
        begin
            tick(1);
            ok = rx_ack[p];
        end
        rx_valid[p] = 1'b0;
        rx_data[p] = ~d;
        tick(4);
    endtask

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        #100000;
        num_errors++;
        $display("watchdog expired");
        conclude();
    end

    initial
    begin
        tick(4);
        chk({18'h0, tx_valid, mem_req, rx_ack, eot}, 32'h0);
        rst_b = 1'b1;
        rdb(3'h7, 32'h0, 16'h0);
        $display("test reset done");
        for (int c = 0; c < 8; c++)
        begin
            // Readback already aimed at the channel being written
            rd_chan = 3'(c);
            wr(3'(c), 1'b0, 1'b0, ROWS[c][47:16]);
            wr(3'(c), 1'b1, 1'b0, {16'h0, ROWS[c][15:0]});
            rdb(3'(c), ROWS[c][47:16], ROWS[c][15:0]);
        end
        $display("test channel table done");
        wr(3'h0, 1'b0, 1'b0, 32'h100);
        wr(3'h0, 1'b1, 1'b0, 32'h2);
        rxw(0, 16'h1234, got);
        chk(32'(got), 32'h1);
        chk(last_waddr, 32'h100);
        chk(32'(last_wdata[7:0]), 32'h34);
        chk(32'(last_wide), 32'h0);
        rxw(0, 16'h0056, got);
        chk(last_waddr, 32'h101);
        chk(32'(eot_n[0]), 32'h1);
        rdb(3'h0, 32'h102, 16'h0);
        rxw(0, 16'h0077, got);
        chk(32'(got), 32'h0);
        wr(3'h1, 1'b0, 1'b0, 32'h200);
        wr(3'h1, 1'b1, 1'b1, 32'h1);
        rxw(1, 16'hbeef, got);
        chk(last_waddr, 32'h200);
        chk({16'h0, last_wdata}, 32'hbeef);
        chk(32'(last_wide), 32'h1);
        rdb(3'h1, 32'h202, 16'h0);
        chk(32'(eot_n[1]), 32'h1);
        $display("test receive done");
        // Slow grants and a stalled receiver: buffer must refuse a third
        slow = 2'h2;
        wr(3'h4, 1'b0, 1'b0, 32'h300);
        wr(3'h4, 1'b1, 1'b1, 32'h3);
        repeat (3)
        begin
            tx_req[0] = 1'b1;
            tick(1);
            tx_req[0] = 1'b0;
            tick(10);
        end
        rdb(3'h4, 32'h304, 16'h1);
        chk(32'(got_q.size()), 32'h0);
        tx_ready = 1'b1;
        tick(30);
        chk(32'(got_q.size()), 32'h3);
        for (int i = 0; i < 3 && i < got_q.size(); i++)
            chk(32'(got_q[i]), {14'h0, 2'h0,
                (16'h300 + 16'(2 * i)) ^ 16'h5a5a});
        chk(32'(eot_n[4]), 32'h1);
        rdb(3'h4, 32'h306, 16'h0);
        g0 = gnt_n;
        tx_req[0] = 1'b1;
        tick(1);
        tx_req[0] = 1'b0;
        tick(20);
        chk(32'(gnt_n), 32'(g0));
        chk(32'(got_q.size()), 32'h3);
        $display("test transmit done");
        // Reset in mid-run: programmed state and the pending request go
        rst_b = 1'b0;
        tick(2);
        rst_b = 1'b1;
        rdb(3'h4, 32'h0, 16'h0);
        wr(3'h4, 1'b1, 1'b0, 32'h1);
        tick(10);
        chk(32'(gnt_n), 32'h0);
        chk(32'(got_q.size()), 32'h3);
        $display("test reset again done");
        conclude();
    end
endmodule // ptc_tb_top

// ==== ptc_top.sv ====
`timescale 1ns/10ps

// Functional notes
// - Eight channels, receive and transmit per peripheral
// - Channels move data without processor help
// - Each channel has a 32-bit programmable pointer
// - Each channel has a 16-bit remaining count
// - One programme covers up to 65535 contiguous items: bytes, or halfwords when the channel is set wide
// - End-of-transfer pulse when count runs out
// - Pointer and count written through peripheral space
module ptc_top
    import ptc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic prog_valid,
    input ptc_pkg::ptc_prog_t prog,
    input wire logic [2:0] rd_chan,
    output logic [31:0] rd_ptr,
    output logic [15:0] rd_cnt,
    input wire logic [3:0] rx_valid,
    input ptc_pkg::ptc_word_t [3:0] rx_data,
    output logic [3:0] rx_ack,
    input wire logic [3:0] tx_req,
    output logic tx_valid,
    input wire logic tx_ready,
    output ptc_pkg::ptc_tx_item_t tx_item,
    output logic mem_req,
    output ptc_pkg::ptc_mem_cmd_t mem_cmd,
    input wire logic mem_gnt,
    input wire logic mem_rvalid,
    input ptc_pkg::ptc_word_t mem_rdata,
    output logic [7:0] eot
);
    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [2:0] ptc_first(input logic [7:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = PTC_NCH - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] ptc_step(input logic wide);
        return wide ? PTC_STEP_HALF : PTC_STEP_BYTE;
    endfunction

    // ************************************************************
    // Channel state
    // ************************************************************
    logic [31:0] ptr_reg [PTC_NCH];
    logic [31:0] ptr_next [PTC_NCH];
    logic [15:0] cnt_reg [PTC_NCH];
    logic [15:0] cnt_next [PTC_NCH];
    logic [7:0] wide_reg, wide_next;
    logic [3:0] tx_pend_reg;
    ptc_state_t state_reg, state_next;
    logic [2:0] ch_reg;
    logic mem_req_reg;
    ptc_mem_cmd_t mem_cmd_reg;
    logic [3:0] rx_ack_reg;
    logic [7:0] eot_reg;
    logic [31:0] rd_ptr_reg;
    logic [15:0] rd_cnt_reg;
    logic [7:0] cnt_nz;
    logic buf_in_ready;

    // ************************************************************
    // Selection and sequencing
    // ************************************************************
    wire idle = state_reg == ST_IDLE;
    wire upd = state_reg == ST_UPDATE;
    // A read is only launched when the buffer has room, so the
    // returning word can never be dropped.
    wire [7:0] pend = {tx_pend_reg & cnt_nz[7:4] & {4{buf_in_ready}},
        rx_valid & cnt_nz[3:0]};
    wire take = idle && (pend != 8'h00);
    wire [2:0] sel = ptc_first(pend);
    wire sel_rx = sel < PTC_TX_BASE;
    wire [3:0] tx_clr = (take && !sel_rx) ? (4'h1 << sel[1:0]) : 4'h0;
    // A fresh request in the clearing cycle is kept
    wire [3:0] tx_pend_next = (tx_pend_reg & ~tx_clr) | tx_req;
    wire last = cnt_reg[ch_reg] == PTC_CNT_LAST;
    wire push = (state_reg == ST_RWAIT) && mem_rvalid;
    wire ptc_tx_item_t push_item = '{periph: ch_reg[1:0], data: mem_rdata};
    wire ptc_mem_cmd_t cmd_next = take ? ptc_mem_cmd_t'{we: sel_rx,
        wide: wide_reg[sel], addr: ptr_reg[sel],
        wdata: rx_data[sel[1:0]]} : mem_cmd_reg;
    wire mem_req_next = take || (mem_req_reg && !mem_gnt);
    wire [3:0] rx_ack_next = (take && sel_rx) ? (4'h1 << sel[1:0]) : 4'h0;
    wire [7:0] eot_next = (upd && last) ? (8'h01 << ch_reg) : 8'h00;

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:
                if (take)
                    state_next = sel_rx ? ST_WRITE : ST_READ;
            ST_WRITE:
                if (mem_gnt)
                    state_next = ST_UPDATE;
            ST_READ:
                if (mem_gnt)
                    state_next = ST_RWAIT;
            ST_RWAIT:
                if (mem_rvalid)
                    state_next = ST_UPDATE;
            ST_UPDATE:
                state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    // Programming wins over an update of the same channel
    always_comb
    begin
        wide_next = wide_reg;
        for (int i = 0; i < PTC_NCH; i++)
        begin
            cnt_nz[i] = cnt_reg[i] != PTC_CNT_ZERO;
            ptr_next[i] = ptr_reg[i];
            cnt_next[i] = cnt_reg[i];
            if (upd && ch_reg == 3'(i))
            begin
                ptr_next[i] = ptr_reg[i] + ptc_step(wide_reg[i]);
                cnt_next[i] = cnt_reg[i] - PTC_CNT_LAST;
            end
            if (prog_valid && prog.chan == 3'(i))
            begin
                if (prog.sel_cnt)
                begin
                    cnt_next[i] = prog.data[15:0];
                    wide_next[i] = prog.wide;
                end
                else
                begin
                    ptr_next[i] = prog.data;
                end
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < PTC_NCH; i++)
        begin
            ptr_reg[i] <= rst_b ? ptr_next[i] : PTC_PTR_RST;
            cnt_reg[i] <= rst_b ? cnt_next[i] : PTC_CNT_ZERO;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            state_reg <= ST_IDLE;
            ch_reg <= 3'h0;
            wide_reg <= 8'h00;
            tx_pend_reg <= 4'h0;
            mem_req_reg <= 1'b0;
            mem_cmd_reg <= '0;
            rx_ack_reg <= 4'h0;
            eot_reg <= 8'h00;
            rd_ptr_reg <= PTC_PTR_RST;
            rd_cnt_reg <= PTC_CNT_ZERO;
        end
        else
        begin
            state_reg <= state_next;
            ch_reg <= take ? sel : ch_reg;
            wide_reg <= wide_next;
            tx_pend_reg <= tx_pend_next;
            mem_req_reg <= mem_req_next;
            mem_cmd_reg <= cmd_next;
            rx_ack_reg <= rx_ack_next;
            eot_reg <= eot_next;
            rd_ptr_reg <= ptr_reg[rd_chan];
            rd_cnt_reg <= cnt_reg[rd_chan];
        end
    end

    // ************************************************************
    // Transmit buffer
    // ************************************************************
    ptc_fifo2 u_txbuf (
        .mclk(mclk),
        .rst_b(rst_b),
        .in_valid(push),
        .in_ready(buf_in_ready),
        .in_item(push_item),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_item(tx_item)
    );

    assign rd_ptr = rd_ptr_reg;
    assign rd_cnt = rd_cnt_reg;
    assign rx_ack = rx_ack_reg;
    assign mem_req = mem_req_reg;
    assign mem_cmd = mem_cmd_reg;
    assign eot = eot_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    property p_ack_onehot;
        @(posedge mclk) disable iff (!rst_b)
        $onehot0(rx_ack_reg) && $onehot0(eot_reg);
    endproperty
    a_ack_onehot: assert property (p_ack_onehot)
        else $error("more than one ack or end pulse");

    property p_rx_write;
        @(posedge mclk) disable iff (!rst_b)
        (rx_ack_reg != 4'h0) |-> mem_req_reg && mem_cmd_reg.we
            && (rx_ack_reg == (4'h1 << ch_reg[1:0]));
    endproperty
    a_rx_write: assert property (p_rx_write)
        else $error("receive ack without matching memory write");

    property p_ptr_step;
        @(posedge mclk) disable iff (!rst_b)
        (upd && !prog_valid) |=> ptr_reg[$past(ch_reg)] ==
            $past(ptr_reg[ch_reg]) + ptc_step($past(wide_reg[ch_reg]));
    endproperty
    a_ptr_step: assert property (p_ptr_step)
        else $error("pointer did not advance by item size");

    property p_cnt_dec;
        @(posedge mclk) disable iff (!rst_b)
        (upd && !prog_valid) |=> cnt_reg[$past(ch_reg)] ==
            $past(cnt_reg[ch_reg]) - PTC_CNT_LAST;
    endproperty
    a_cnt_dec: assert property (p_cnt_dec)
        else $error("count did not decrement");

    property p_prog_ptr;
        @(posedge mclk) disable iff (!rst_b)
        (prog_valid && !prog.sel_cnt) |=> ##1
            (rd_ptr_reg == $past(prog.data, 2)) || ($past(rd_chan) !=
            $past(prog.chan, 2));
    endproperty
    a_prog_ptr: assert property (p_prog_ptr)
        else $error("programmed pointer not read back");

    property p_no_zero;
        @(posedge mclk) disable iff (!rst_b)
        $rose(mem_req_reg) |-> cnt_reg[ch_reg] != PTC_CNT_ZERO;
    endproperty
    a_no_zero: assert property (p_no_zero)
        else $error("transfer started on empty channel");

    property p_addr;
        @(posedge mclk) disable iff (!rst_b)
        $rose(mem_req_reg) |-> mem_cmd_reg.addr == ptr_reg[ch_reg];
    endproperty
    a_addr: assert property (p_addr)
        else $error("memory address differs from pointer");

    property p_eot;
        @(posedge mclk) disable iff (!rst_b)
        (eot_reg != 8'h00) |-> $past(upd) && $past(last)
            && (eot_reg == (8'h01 << $past(ch_reg)));
    endproperty
    a_eot: assert property (p_eot)
        else $error("end pulse without last item");

    property p_tx_hold;
        @(posedge mclk) disable iff (!rst_b)
        (tx_valid && !tx_ready) |=> tx_valid && $stable(tx_item);
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("transmit word lost under stall");

    c_rx_done: cover property (@(posedge mclk) disable iff (!rst_b)
        eot_reg[0]);
    c_tx_done: cover property (@(posedge mclk) disable iff (!rst_b)
        eot_reg[4]);
    c_buf_full: cover property (@(posedge mclk) disable iff (!rst_b)
        !buf_in_ready && tx_valid && !tx_ready);
endmodule // ptc_top
